/* tdrc_pkg.sv */
// Package: register map, field layout, reset values and timing for the reflectometry control
package tdrc_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [15:0] ADDR_GEN_CFG = 16'h0180;
	localparam logic [15:0] ADDR_SIL_CFG = 16'h0181;
	localparam logic [15:0] ADDR_SEG_LO = 16'h0182;
	localparam logic [15:0] ADDR_SEG_HI = 16'h0183;
	localparam logic [15:0] ADDR_HOLD_LO = 16'h0184;
	localparam logic [15:0] ADDR_HOLD_HI = 16'h0185;
	localparam logic [15:0] ADDR_CTRL = 16'h0186;
	localparam logic [15:0] ADDR_STATUS = 16'h0187;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'h0188;
	localparam logic [15:0] ADDR_IRQ_CLR = 16'h0189;
	localparam logic [15:0] ADDR_IRQ_EN = 16'h018a;

	// ********************************
	// Reset values and writable masks
	// ********************************
	localparam logic [15:0] RST_GEN_CFG = 16'h3a90;
	localparam logic [15:0] RST_SIL_CFG = 16'hc850;
	localparam logic [15:0] RST_SEG_LO = 16'h5326;
	localparam logic [15:0] RST_SEG_HI = 16'ha01e;
	localparam logic [15:0] RST_HOLD_LO = 16'he976;
	localparam logic [15:0] RST_HOLD_HI = 16'h19cf;
	localparam logic [15:0] MSK_GEN_CFG = 16'hffff;
	localparam logic [15:0] MSK_SIL_CFG = 16'hfff0;
	localparam logic [15:0] MSK_SEG_LO = 16'h7fff;
	localparam logic [15:0] MSK_SEG_HI = 16'hff3f;
	localparam logic [15:0] MSK_HOLD_LO = 16'hff77;
	localparam logic [15:0] MSK_HOLD_HI = 16'h39ff;

	// ********************************
	// Field positions
	// ********************************
	localparam int POS_PAIR_CD_SKIP = 12;
	localparam int POS_CROSS_LISTEN_DISABLE = 11;
	localparam int POS_LINK_PULSE_CHECK = 10;
	localparam int POS_AVG_CODE = 7;
	localparam int POS_SEG_COUNT = 4;
	localparam int POS_CYCLE_TIME = 0;
	localparam int POS_SIL_TH = 8;
	localparam int POS_POST_TIMER = 6;
	localparam int POS_PRE_TIMER = 4;
	localparam int POS_SEG1 = 0;
	localparam int POS_SEG2 = 5;
	localparam int POS_SEG3 = 10;
	localparam int POS_SEG4 = 0;
	localparam int POS_SEG5 = 8;
	localparam int POS_HOLD1 = 0;
	localparam int POS_HOLD2 = 4;
	localparam int POS_HOLD3 = 8;
	localparam int POS_HOLD4 = 12;
	localparam int POS_HOLD5 = 0;
	localparam int POS_CTRL_START = 0;
	localparam int POS_CTRL_ABORT = 1;
	localparam logic [2:0] AVG_CODE_RESERVED = 3'h7;
	localparam logic [2:0] AVG_CODE_MAX = 3'h6;
	localparam logic [2:0] SEG_COUNT_MAX = 3'h5;
	localparam logic [2:0] SEG_COUNT_MIN = 3'h1;
	localparam logic [1:0] CHAN_LAST_SKIP = 2'h1;
	localparam logic [1:0] CHAN_LAST_ALL = 2'h3;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int MICROSECOND_NS = 1000;
	localparam int SILENCE_UNIT_US = 1;
	localparam logic [15:0] CYCLES_PER_US = 16'(MICROSECOND_NS / CLK_PERIOD_NS);
	localparam logic [15:0] SILENCE_UNIT_CYC = 16'(SILENCE_UNIT_US * MICROSECOND_NS / CLK_PERIOD_NS);

	// Interrupt bit layout
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_PEAK = 2;
	localparam int IRQ_W = 3;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PRE = 5'h02,
		ST_SEG = 5'h04,
		ST_PAD = 5'h08,
		ST_POST = 5'h10
	} tdrc_state_e_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tdrc_bus_req_t;

	typedef struct packed {
		logic [7:0] energy;
		logic link_pulse;
		logic peak_max;
	} tdrc_line_in_t;

endpackage

/* tdrc_timer.sv */
// Down-counting phase timer with a registered expiry flag
`timescale 1ns/100ps
module tdrc_timer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic load,
	input wire logic [15:0] load_value,
	output logic expired
);
	typedef struct packed {
		logic [15:0] cnt;
		logic zero;
	} tdrc_timer_st_t;

	tdrc_timer_st_t s_r;
	tdrc_timer_st_t s_nxt;

	// Expired stands in the last counted cycle, so the user acts on the
	// load_value-th edge and a phase lasts exactly load_value cycles
	always_comb begin
		s_nxt = s_r;
		if (load) begin
			s_nxt.cnt = load_value;
			s_nxt.zero = (load_value <= 16'h0001);
		end else if (s_r.cnt != 16'h0000) begin
			s_nxt.cnt = s_r.cnt - 16'h0001;
			s_nxt.zero = (s_r.cnt <= 16'h0002);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '{cnt: 16'h0000, zero: 1'b1};
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign expired = s_r.zero;

	property p_timer_load;
		@(posedge clk_sys) disable iff (reset)
		(ce && load && load_value == 16'h0003) ##1 (ce && !load) [*3] |-> expired;
	endproperty
	a_timer_load: assert property (p_timer_load) else $error("timer did not expire on time");
endmodule

/* tdrc_ctrl.sv */
// Reflectometry cable test configuration registers and test sequencer
`timescale 1ns/100ps
module tdrc_ctrl (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire tdrc_pkg::tdrc_bus_req_t bus_req,
	output logic [15:0] reg_rdata,
	input wire tdrc_pkg::tdrc_line_in_t line_in,
	output logic tx_active,
	output logic [1:0] tx_channel,
	output logic [3:0] listen_mask,
	output logic [2:0] seg_index,
	output logic peak_found,
	output logic test_busy,
	output logic irq
);
	typedef struct packed {
		tdrc_pkg::tdrc_state_e_t st;
		logic [15:0] gen_cfg;
		logic [15:0] sil_cfg;
		logic [15:0] seg_lo;
		logic [15:0] seg_hi;
		logic [15:0] hold_lo;
		logic [15:0] hold_hi;
		logic [15:0] rdata;
		logic [1:0] chan;
		logic [6:0] avg_cnt;
		logic [2:0] seg;
		logic [3:0] hold_cnt;
		logic hold_act;
		logic tx_active;
		logic [3:0] listen;
		logic peak;
		logic fail_pre;
		logic fail_post;
		logic done;
		logic [tdrc_pkg::IRQ_W-1:0] irq_stat;
		logic [tdrc_pkg::IRQ_W-1:0] irq_en;
		logic irq;
		logic busy;
	} tdrc_ctrl_st_t;

	tdrc_ctrl_st_t s_r;
	tdrc_ctrl_st_t s_nxt;
	logic ph_load;
	logic [15:0] ph_value;
	logic ph_expired;
	logic cy_load;
	logic [15:0] cy_value;
	logic cy_expired;

	// ********************************
	// Configuration decode
	// ********************************
	logic pair_cd_skip;
	logic cross_listen_disable;
	logic link_pulse_check;
	logic [2:0] average_count_code;
	logic [2:0] segment_count;
	logic [2:0] seg_last;
	logic [3:0] cycle_time_us;
	logic [7:0] silence_energy_threshold;
	logic [1:0] post_quiet_timer;
	logic [1:0] pre_quiet_timer;
	logic [6:0] avg_last;
	logic [1:0] chan_last;
	logic energy_hit;
	logic pulse_hit;

	assign pair_cd_skip = s_r.gen_cfg[tdrc_pkg::POS_PAIR_CD_SKIP];
	assign cross_listen_disable = s_r.gen_cfg[tdrc_pkg::POS_CROSS_LISTEN_DISABLE];
	assign link_pulse_check = s_r.gen_cfg[tdrc_pkg::POS_LINK_PULSE_CHECK];
	assign average_count_code = s_r.gen_cfg[tdrc_pkg::POS_AVG_CODE +: 3];
	assign segment_count = s_r.gen_cfg[tdrc_pkg::POS_SEG_COUNT +: 3];
	assign cycle_time_us = s_r.gen_cfg[tdrc_pkg::POS_CYCLE_TIME +: 4];
	assign silence_energy_threshold = s_r.sil_cfg[tdrc_pkg::POS_SIL_TH +: 8];
	assign post_quiet_timer = s_r.sil_cfg[tdrc_pkg::POS_POST_TIMER +: 2];
	assign pre_quiet_timer = s_r.sil_cfg[tdrc_pkg::POS_PRE_TIMER +: 2];

	// Reserved averaging code behaves as the largest legal one
	assign avg_last = (average_count_code == tdrc_pkg::AVG_CODE_RESERVED) ?
		7'((8'h01 << tdrc_pkg::AVG_CODE_MAX) - 8'h01) :
		7'((8'h01 << average_count_code) - 8'h01);
	// Only five segments have lengths; zero still runs one
	assign seg_last = (segment_count > tdrc_pkg::SEG_COUNT_MAX) ? tdrc_pkg::SEG_COUNT_MAX :
		(segment_count < tdrc_pkg::SEG_COUNT_MIN) ? tdrc_pkg::SEG_COUNT_MIN :
		segment_count;
	assign chan_last = pair_cd_skip ? tdrc_pkg::CHAN_LAST_SKIP : tdrc_pkg::CHAN_LAST_ALL;
	assign energy_hit = line_in.energy > silence_energy_threshold;
	assign pulse_hit = link_pulse_check && line_in.link_pulse;

	function automatic logic [15:0] seg_length(input logic [2:0] seg);
		case (seg)
			3'h1: seg_length = {11'h000, s_r.seg_lo[tdrc_pkg::POS_SEG1 +: 5]};
			3'h2: seg_length = {11'h000, s_r.seg_lo[tdrc_pkg::POS_SEG2 +: 5]};
			3'h3: seg_length = {11'h000, s_r.seg_lo[tdrc_pkg::POS_SEG3 +: 5]};
			3'h4: seg_length = {10'h000, s_r.seg_hi[tdrc_pkg::POS_SEG4 +: 6]};
			default: seg_length = {8'h00, s_r.seg_hi[tdrc_pkg::POS_SEG5 +: 8]};
		endcase
	endfunction

	function automatic logic [3:0] seg_holdoff(input logic [2:0] seg);
		case (seg)
			3'h1: seg_holdoff = {1'b0, s_r.hold_lo[tdrc_pkg::POS_HOLD1 +: 3]};
			3'h2: seg_holdoff = {1'b0, s_r.hold_lo[tdrc_pkg::POS_HOLD2 +: 3]};
			3'h3: seg_holdoff = s_r.hold_lo[tdrc_pkg::POS_HOLD3 +: 4];
			3'h4: seg_holdoff = s_r.hold_lo[tdrc_pkg::POS_HOLD4 +: 4];
			default: seg_holdoff = s_r.hold_hi[tdrc_pkg::POS_HOLD5 +: 4];
		endcase
	endfunction

	function automatic logic [3:0] chan_listen(input logic [1:0] ch, input logic [1:0] last,
		input logic solo);
		if (solo) begin
			chan_listen = 4'h1 << ch;
		end else begin
			chan_listen = (last == tdrc_pkg::CHAN_LAST_SKIP) ? 4'h3 : 4'hf;
		end
	endfunction

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		logic [tdrc_pkg::IRQ_W-1:0] ev;
		logic [tdrc_pkg::IRQ_W-1:0] clr;
		logic start;
		logic abort;
		ev = '0;
		clr = '0;
		start = 1'b0;
		abort = 1'b0;
		s_nxt = s_r;
		ph_load = 1'b0;
		ph_value = 16'h0000;
		cy_load = 1'b0;
		cy_value = 16'h0000;
		s_nxt.peak = 1'b0;
		s_nxt.rdata = 16'h0000;

		// Register writes; software keeps config still during a run
		if (bus_req.wr) begin
			if (bus_req.addr == tdrc_pkg::ADDR_GEN_CFG) begin
				s_nxt.gen_cfg = bus_req.wdata & tdrc_pkg::MSK_GEN_CFG;
			end else if (bus_req.addr == tdrc_pkg::ADDR_SIL_CFG) begin
				s_nxt.sil_cfg = bus_req.wdata & tdrc_pkg::MSK_SIL_CFG;
			end else if (bus_req.addr == tdrc_pkg::ADDR_SEG_LO) begin
				s_nxt.seg_lo = bus_req.wdata & tdrc_pkg::MSK_SEG_LO;
			end else if (bus_req.addr == tdrc_pkg::ADDR_SEG_HI) begin
				s_nxt.seg_hi = bus_req.wdata & tdrc_pkg::MSK_SEG_HI;
			end else if (bus_req.addr == tdrc_pkg::ADDR_HOLD_LO) begin
				s_nxt.hold_lo = bus_req.wdata & tdrc_pkg::MSK_HOLD_LO;
			end else if (bus_req.addr == tdrc_pkg::ADDR_HOLD_HI) begin
				s_nxt.hold_hi = bus_req.wdata & tdrc_pkg::MSK_HOLD_HI;
			end else if (bus_req.addr == tdrc_pkg::ADDR_CTRL) begin
				start = bus_req.wdata[tdrc_pkg::POS_CTRL_START];
				abort = bus_req.wdata[tdrc_pkg::POS_CTRL_ABORT];
			end else if (bus_req.addr == tdrc_pkg::ADDR_IRQ_CLR) begin
				clr = bus_req.wdata[tdrc_pkg::IRQ_W-1:0];
			end else if (bus_req.addr == tdrc_pkg::ADDR_IRQ_EN) begin
				s_nxt.irq_en = bus_req.wdata[tdrc_pkg::IRQ_W-1:0];
			end
		end

		// Register reads, data stand one cycle later
		if (bus_req.rd) begin
			if (bus_req.addr == tdrc_pkg::ADDR_GEN_CFG) begin
				s_nxt.rdata = s_r.gen_cfg;
			end else if (bus_req.addr == tdrc_pkg::ADDR_SIL_CFG) begin
				s_nxt.rdata = s_r.sil_cfg;
			end else if (bus_req.addr == tdrc_pkg::ADDR_SEG_LO) begin
				s_nxt.rdata = s_r.seg_lo;
			end else if (bus_req.addr == tdrc_pkg::ADDR_SEG_HI) begin
				s_nxt.rdata = s_r.seg_hi;
			end else if (bus_req.addr == tdrc_pkg::ADDR_HOLD_LO) begin
				s_nxt.rdata = s_r.hold_lo;
			end else if (bus_req.addr == tdrc_pkg::ADDR_HOLD_HI) begin
				s_nxt.rdata = s_r.hold_hi;
			end else if (bus_req.addr == tdrc_pkg::ADDR_STATUS) begin
				s_nxt.rdata = {5'h00, s_r.chan, s_r.seg, 1'b0, s_r.tx_active,
					s_r.fail_post, s_r.fail_pre, s_r.done, (s_r.st != tdrc_pkg::ST_IDLE)};
			end else if (bus_req.addr == tdrc_pkg::ADDR_IRQ_STAT) begin
				s_nxt.rdata = {13'h0000, s_r.irq_stat};
			end else if (bus_req.addr == tdrc_pkg::ADDR_IRQ_EN) begin
				s_nxt.rdata = {13'h0000, s_r.irq_en};
			end
		end

		// Hold-off after the maximum, dropped if the segment ends first
		if (s_r.hold_act) begin
			if (s_r.hold_cnt == 4'h0) begin
				s_nxt.hold_act = 1'b0;
				s_nxt.peak = 1'b1;
				ev[tdrc_pkg::IRQ_PEAK] = 1'b1;
			end else begin
				s_nxt.hold_cnt = s_r.hold_cnt - 4'h1;
			end
		end

		case (s_r.st)
			tdrc_pkg::ST_IDLE: begin
				if (start) begin
					s_nxt.st = tdrc_pkg::ST_PRE;
					s_nxt.done = 1'b0;
					s_nxt.fail_pre = 1'b0;
					s_nxt.fail_post = 1'b0;
					s_nxt.chan = 2'h0;
					s_nxt.avg_cnt = 7'h00;
					ph_load = 1'b1;
					ph_value = 16'(({14'h0000, pre_quiet_timer} + 16'h0001) *
						tdrc_pkg::SILENCE_UNIT_CYC);
				end
			end
			tdrc_pkg::ST_PRE: begin
				if (energy_hit || pulse_hit) begin
					s_nxt.fail_pre = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.st = tdrc_pkg::ST_IDLE;
					ev[tdrc_pkg::IRQ_DONE] = 1'b1;
					ev[tdrc_pkg::IRQ_FAIL] = 1'b1;
				end else if (ph_expired) begin
					s_nxt.st = tdrc_pkg::ST_SEG;
					s_nxt.seg = 3'h1;
					s_nxt.tx_active = 1'b1;
					s_nxt.listen = chan_listen(s_r.chan, chan_last, cross_listen_disable);
					ph_load = 1'b1;
					ph_value = seg_length(3'h1);
					cy_load = 1'b1;
					cy_value = 16'({12'h000, cycle_time_us} * tdrc_pkg::CYCLES_PER_US);
				end
			end
			tdrc_pkg::ST_SEG: begin
				if (line_in.peak_max && !s_r.hold_act) begin
					s_nxt.hold_act = 1'b1;
					s_nxt.hold_cnt = seg_holdoff(s_r.seg);
				end
				if (ph_expired) begin
					s_nxt.hold_act = 1'b0;
					if (s_r.seg >= seg_last) begin
						s_nxt.st = tdrc_pkg::ST_PAD;
						s_nxt.tx_active = 1'b0;
						s_nxt.listen = 4'h0;
					end else begin
						s_nxt.seg = s_r.seg + 3'h1;
						ph_load = 1'b1;
						ph_value = seg_length(s_r.seg + 3'h1);
					end
				end
			end
			tdrc_pkg::ST_PAD: begin
				// Cycle timer paces averaged cycles even if segments are short
				if (cy_expired) begin
					if (s_r.avg_cnt != avg_last) begin
						s_nxt.avg_cnt = s_r.avg_cnt + 7'h01;
					end else if (s_r.chan != chan_last) begin
						s_nxt.avg_cnt = 7'h00;
						s_nxt.chan = s_r.chan + 2'h1;
					end
					if (s_r.avg_cnt == avg_last && s_r.chan == chan_last) begin
						s_nxt.st = tdrc_pkg::ST_POST;
						s_nxt.seg = 3'h0;
						ph_load = 1'b1;
						ph_value = 16'(({14'h0000, post_quiet_timer} + 16'h0001) *
							tdrc_pkg::SILENCE_UNIT_CYC);
					end else begin
						s_nxt.st = tdrc_pkg::ST_SEG;
						s_nxt.seg = 3'h1;
						s_nxt.tx_active = 1'b1;
						s_nxt.listen = chan_listen(s_nxt.chan, chan_last, cross_listen_disable);
						ph_load = 1'b1;
						ph_value = seg_length(3'h1);
						cy_load = 1'b1;
						cy_value = 16'({12'h000, cycle_time_us} * tdrc_pkg::CYCLES_PER_US);
					end
				end
			end
			tdrc_pkg::ST_POST: begin
				if (energy_hit || pulse_hit) begin
					s_nxt.fail_post = 1'b1;
				end
				if (ph_expired) begin
					s_nxt.st = tdrc_pkg::ST_IDLE;
					s_nxt.done = 1'b1;
					ev[tdrc_pkg::IRQ_DONE] = 1'b1;
					ev[tdrc_pkg::IRQ_FAIL] = s_r.fail_post || energy_hit || pulse_hit;
				end
			end
			default: begin
				s_nxt.st = tdrc_pkg::ST_IDLE;
			end
		endcase

		if (abort && s_r.st != tdrc_pkg::ST_IDLE) begin
			s_nxt.st = tdrc_pkg::ST_IDLE;
			s_nxt.tx_active = 1'b0;
			s_nxt.listen = 4'h0;
			s_nxt.hold_act = 1'b0;
		end

		// Busy kept in a flop so the output has no decode behind it
		s_nxt.busy = (s_nxt.st != tdrc_pkg::ST_IDLE);

		// An event in the clearing cycle survives
		s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
	end

	// ********************************
	// State register
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_r <= '0;
			s_r.st <= tdrc_pkg::ST_IDLE;
			s_r.gen_cfg <= tdrc_pkg::RST_GEN_CFG;
			s_r.sil_cfg <= tdrc_pkg::RST_SIL_CFG;
			s_r.seg_lo <= tdrc_pkg::RST_SEG_LO;
			s_r.seg_hi <= tdrc_pkg::RST_SEG_HI;
			s_r.hold_lo <= tdrc_pkg::RST_HOLD_LO;
			s_r.hold_hi <= tdrc_pkg::RST_HOLD_HI;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	tdrc_timer u_phase_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.load(ph_load),
		.load_value(ph_value),
		.expired(ph_expired)
	);

	tdrc_timer u_cycle_timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.load(cy_load),
		.load_value(cy_value),
		.expired(cy_expired)
	);

	assign reg_rdata = s_r.rdata;
	assign tx_active = s_r.tx_active;
	assign tx_channel = s_r.chan;
	assign listen_mask = s_r.listen;
	assign seg_index = s_r.seg;
	assign peak_found = s_r.peak;
	assign test_busy = s_r.busy;
	assign irq = s_r.irq;

	// ********************************
	// Checks
	// ********************************
	property p_skip_cd;
		@(posedge clk_sys) disable iff (reset)
		(tx_active && pair_cd_skip) |-> (tx_channel <= 2'h1);
	endproperty
	a_skip_cd: assert property (p_skip_cd) else $error("channel C or D driven while skipped");

	property p_solo_listen;
		@(posedge clk_sys) disable iff (reset)
		(tx_active && cross_listen_disable) |-> (listen_mask == (4'h1 << tx_channel));
	endproperty
	a_solo_listen: assert property (p_solo_listen) else $error("listening across channels");

	property p_pulse_fail;
		@(posedge clk_sys) disable iff (reset)
		(ce && s_r.st == tdrc_pkg::ST_PRE && link_pulse_check && line_in.link_pulse &&
			!bus_req.wr) |=> (s_r.fail_pre && !test_busy);
	endproperty
	a_pulse_fail: assert property (p_pulse_fail) else $error("link pulse not failing");

	property p_seg_range;
		@(posedge clk_sys) disable iff (reset)
		tx_active |-> (seg_index >= 3'h1 && seg_index <= seg_last);
	endproperty
	a_seg_range: assert property (p_seg_range) else $error("segment index out of range");

	property p_pre_energy;
		@(posedge clk_sys) disable iff (reset)
		(ce && s_r.st == tdrc_pkg::ST_PRE && energy_hit && !bus_req.wr)
			|=> (s_r.fail_pre && s_r.done && !tx_active);
	endproperty
	a_pre_energy: assert property (p_pre_energy) else $error("pre energy not failing");

	property p_post_energy;
		@(posedge clk_sys) disable iff (reset)
		(ce && s_r.st == tdrc_pkg::ST_POST && energy_hit && !bus_req.wr) |=> s_r.fail_post;
	endproperty
	a_post_energy: assert property (p_post_energy) else $error("post energy not failing");

	property p_reset_words;
		@(posedge clk_sys) $fell(reset) |-> (s_r.gen_cfg == 16'h3a90 &&
			s_r.sil_cfg == 16'hc850 && s_r.seg_lo == 16'h5326 && s_r.seg_hi == 16'ha01e);
	endproperty
	a_reset_words: assert property (p_reset_words) else $error("bad config reset");

	property p_peak_holdoff;
		@(posedge clk_sys) disable iff (reset)
		$rose(peak_found) |-> $past(s_r.hold_act);
	endproperty
	a_peak_holdoff: assert property (p_peak_holdoff) else $error("peak without hold-off");

	property p_start_seq;
		@(posedge clk_sys) disable iff (reset)
		(ce && !test_busy && bus_req.wr && bus_req.addr == tdrc_pkg::ADDR_CTRL &&
			bus_req.wdata[0] && !bus_req.wdata[1]) |=> (s_r.st == tdrc_pkg::ST_PRE && test_busy);
	endproperty
	a_start_seq: assert property (p_start_seq) else $error("start not taken");

	c_pass: cover property (@(posedge clk_sys) disable iff (reset)
		(s_r.st == tdrc_pkg::ST_POST) ##1 (s_r.done && !s_r.fail_post));
	c_pre_fail: cover property (@(posedge clk_sys) disable iff (reset) $rose(s_r.fail_pre));
	c_peak: cover property (@(posedge clk_sys) disable iff (reset) peak_found);
	c_irq: cover property (@(posedge clk_sys) disable iff (reset) $rose(irq));
endmodule

/* tdrc_cable.sv */
// Cable model: line energy, link pulses and echo peaks seen by the tester
`timescale 1ns/100ps
module tdrc_cable (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic tx_active,
	input wire logic [2:0] mode,
	output tdrc_pkg::tdrc_line_in_t line_in
);
	logic [7:0] hum_r;
	logic sent_r;
	always_ff @(posedge clk_sys) begin
		hum_r <= reset ? 8'h11 : {hum_r[6:0], hum_r[7] ^ hum_r[5]};
		sent_r <= !reset && mode[1] && (sent_r || tx_active);
	end
	// A quiet cable still hums, always well under any threshold above 0x7f
	always_comb begin
		line_in.energy = mode[0] ? 8'hff : {1'b0, hum_r[6:0]};
		line_in.link_pulse = mode[1] && sent_r && !tx_active;
		line_in.peak_max = mode[2] && tx_active;
	end
endmodule

/* test_tdrc_ctrl.sv */
// Self-checking bench for the reflectometry test controller
`timescale 1ns/100ps
module test_tdrc_ctrl;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	tdrc_pkg::tdrc_bus_req_t bus_req = '0;
	tdrc_pkg::tdrc_line_in_t line_in;
	logic [15:0] reg_rdata;
	logic tx_active, peak_found, test_busy, irq;
	logic [1:0] tx_channel;
	logic [3:0] listen_mask;
	logic [2:0] seg_index;
	logic [2:0] mode = 3'h0;
	logic [15:0] lfsr_r = 16'h000f;
	logic [3:0] ch_seen = 4'h0;
	logic mask_bad = 1'b0;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_tx = 0;
	int n_peak = 0;
	logic [15:0] rv [6] = '{16'h3a90, 16'hc850, 16'h5326, 16'ha01e, 16'he976, 16'h19cf};
	logic [15:0] mk [4] = '{16'hffff, 16'hfff0, 16'h7fff, 16'hff3f};
	always #25 clk_sys = ~clk_sys;
	tdrc_ctrl tdrc_ctrl_inst (.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .bus_req(bus_req),
		.reg_rdata(reg_rdata), .line_in(line_in), .tx_active(tx_active), .tx_channel(tx_channel),
		.listen_mask(listen_mask), .seg_index(seg_index), .peak_found(peak_found),
		.test_busy(test_busy), .irq(irq));
	tdrc_cable tdrc_cable_inst (.clk_sys(clk_sys), .reset(reset), .tx_active(tx_active),
		.mode(mode), .line_in(line_in));
	always @(posedge clk_sys) begin
		if (tx_active === 1'b1) begin
			n_tx <= n_tx + 1;
			ch_seen[tx_channel] <= 1'b1;
			if (listen_mask !== 4'h1 << tx_channel) mask_bad <= 1'b1;
			if (seg_index !== 3'h1 && seg_index !== 3'h2) mask_bad <= 1'b1;
		end
		if (peak_found === 1'b1) n_peak <= n_peak + 1;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Strobe, drop, then one idle edge so no signal is assigned twice in a step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic rc(input string what, input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(what, exp, d);
	endtask
	task automatic run(input logic [15:0] cfg, input int lim);
		n_tx = 0;
		n_peak = 0;
		ch_seen = 4'h0;
		wr(tdrc_pkg::ADDR_GEN_CFG, cfg);
		wr(tdrc_pkg::ADDR_CTRL, 16'h0001);
		for (int i = 0; i < lim && test_busy !== 1'b0; i++) @(posedge clk_sys);
		chk("busy", 16'h0, {15'h0, test_busy});
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Budget: seven short runs of under 200 cycles each
	initial begin
		#1000000;
		n_mismatch++;
		test_done();
	end
	initial begin
		logic [15:0] v;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 6; i++) rc("reset value", 16'h0180 + 16'(i), rv[i]);
		rc("unmapped", 16'h0190, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			lfsr_r = lfsr(lfsr_r);
			wr(16'h0180 + 16'(i % 4), lfsr_r);
			rc("field write", 16'h0180 + 16'(i % 4), lfsr_r & mk[i % 4]);
		end
		// Threshold 0xc8, shortest silences, segments of 3 and 4, no hold-off
		wr(tdrc_pkg::ADDR_SIL_CFG, 16'hc800);
		wr(tdrc_pkg::ADDR_SEG_LO, 16'h0083);
		wr(tdrc_pkg::ADDR_HOLD_LO, 16'h0000);
		wr(tdrc_pkg::ADDR_IRQ_EN, 16'h0007);
		for (int s = 0; s < 2; s++) begin
			mode <= 3'h4;
			run(s ? 16'h1c21 : 16'h0c21, 400);
			chk("tx cycles", s ? 16'd14 : 16'd28, 16'(n_tx));
			chk("channels", s ? 16'h3 : 16'hf, {12'h0, ch_seen});
			chk("listen", 16'h0, {15'h0, mask_bad});
			chk("peak seen", 16'h1, {15'h0, n_peak > 0});
			rc("irq status", tdrc_pkg::ADDR_IRQ_STAT, 16'h0005);
			chk("irq", 16'h1, {15'h0, irq});
			wr(tdrc_pkg::ADDR_IRQ_CLR, 16'h0007);
			chk("irq clear", 16'h0, {15'h0, irq});
		end
		mode <= 3'h1;
		run(16'h1c21, 100);
		chk("tx after pre fail", 16'h0, 16'(n_tx));
		rd(tdrc_pkg::ADDR_STATUS, v);
		chk("pre fail", 16'h1, {15'h0, v[2]});
		rc("fail irq", tdrc_pkg::ADDR_IRQ_STAT, 16'h0003);
		wr(tdrc_pkg::ADDR_IRQ_CLR, 16'h0007);
		for (int c = 0; c < 2; c++) begin
			mode <= 3'h2;
			run(c ? 16'h1821 : 16'h1c21, 400);
			rd(tdrc_pkg::ADDR_STATUS, v);
			chk("post fail", c ? 16'h0 : 16'h1, {15'h0, v[3]});
			chk("ran to end", 16'd14, 16'(n_tx));
		end
		// Cable still pulsing from the last run, so the pre-silence must fail
		run(16'h1c21, 100);
		chk("pulse pre fail", 16'h0, 16'(n_tx));
		mode <= 3'h0;
		wr(tdrc_pkg::ADDR_IRQ_CLR, 16'h0007);
		wr(tdrc_pkg::ADDR_IRQ_EN, 16'h0000);
		run(16'h1c21, 400);
		chk("masked irq", 16'h0, {15'h0, irq});
		rc("masked status", tdrc_pkg::ADDR_IRQ_STAT, 16'h0001);
		wr(tdrc_pkg::ADDR_IRQ_EN, 16'h0001);
		chk("enabled irq", 16'h1, {15'h0, irq});
		wr(tdrc_pkg::ADDR_IRQ_CLR, 16'h0001);
		chk("cleared irq", 16'h0, {15'h0, irq});
		wr(tdrc_pkg::ADDR_CTRL, 16'h0001);
		wr(tdrc_pkg::ADDR_CTRL, 16'h0002);
		chk("abort", 16'h0, {15'h0, test_busy});
		rc("no done", tdrc_pkg::ADDR_IRQ_STAT, 16'h0000);
		test_done();
	end
endmodule
